// >>> rtl/ecl_loader.sv
// Serial EEPROM configuration loader with Wishbone register access and descriptor RAM.
//
// Notes on behaviour
// - A reload command re-reads the EEPROM image from byte zero.
// - First byte other than A5 means no EEPROM; the load fails.
// - Loaded flag is set only after a successful image fetch.
// - Bytes one to six become the station MAC address.
// - Byte 07h is the full-speed, 08h the hi-speed polling interval.
// - Byte 09h holds the configuration flags.
// - Bytes 0Ah and 0Bh give the language ID, low byte first.
// - Bytes 0Ch to 1Dh are length and word offset pairs; zero length means absent.
// - A descriptor byte address is its word offset times two.
// - Byte 1Eh wakes pins seven to zero, byte 1Fh pins ten to eight.
// - Byte 20h holds the power management event flags.
// - Descriptor RAM and attribute registers may replace the EEPROM source.
// - Remote wake follows config attributes only if RAM is written after attributes.
// - Commands start on busy set; busy clears at completion; writes ignored meanwhile.
// - Timeout flag sets when the EEPROM stays silent for 30 ms.
// - A valid image is copied whole into the 512-byte SRAM.
// - The USB port stays disconnected until the first load ends.
`timescale 1ns/1ps
`include "ecl_regs.svh"
module ecl_loader
  import ecl_pkg::*;
#(
  parameter int TMO_CYC = `ECL_TMO_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Wishbone slave.
  input wire ecl_wb_req_s wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial EEPROM pins.
  output ecl_rom_pins_s rom_out,
  input wire logic rom_do,
  // System reload request and USB side.
  input wire logic soft_reset_request,
  input wire logic desc_rd,
  input wire logic [3:0] desc_sel,
  input wire logic [7:0] desc_idx,
  output logic [7:0] desc_data,
  output logic desc_valid,
  output logic usb_connect,
  output ecl_cfg_s cfg_out
);
  ecl_st_s s, n;
  logic [7:0] mem [0:511];
  logic [7:0] mem_dq;
  logic [7:0] mem_bq;
  logic mem_we;
  logic [8:0] mem_a;
  logic [7:0] mem_d;
  logic [8:0] desc_a;
  logic rom_in;
  logic tick;
  logic [31:0] rd_word;
  logic [31:0] wmask;
  logic [31:0] wv;
  logic bus_wr;
  logic [7:0] rbyte;

  ////////////////////////////////////////////////////////////////////////////////
  // Data-out line from the EEPROM is a pin, so it is synchronised first.
  ecl_sync u_sync (
    .clk(clk),
    .nrst(nrst),
    .din(rom_do),
    .dout(rom_in)
  );

  // Header for a serial command: start bit, two opcode bits, nine address bits, data.
  function automatic logic [19:0] hdr_word(input logic [2:0] c, input logic [8:0] a,
                                           input logic [7:0] d);
    logic [19:0] w;
    w = {1'b1, 2'b10, a, 8'h00};
    if (c == `ECL_CMD_WRITE) begin
      w = {1'b1, 2'b01, a, d};
    end else if (c == `ECL_CMD_ERASE) begin
      w = {1'b1, 2'b11, a, 8'h00};
    end else if (c == `ECL_CMD_EWEN) begin
      w = {1'b1, 4'b0011, 7'h00, 8'h00};
    end else if (c == `ECL_CMD_EWDS) begin
      w = {1'b1, 4'b0000, 7'h00, 8'h00};
    end else if (c == `ECL_CMD_ERAL) begin
      w = {1'b1, 4'b0010, 7'h00, 8'h00};
    end else if (c == `ECL_CMD_WRAL) begin
      w = {1'b1, 4'b0001, 7'h00, d};
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register readback, byte-lane merge and bus write qualifier.
  always_comb begin
    rd_word = 32'h0;
    if (wb_req.adr == `ECL_OFF_CMD) begin
      rd_word = {s.busy, s.cmd, 17'h0, s.tmo, s.loaded, s.addr};
    end else if (wb_req.adr == `ECL_OFF_DATA) begin
      rd_word = {24'h0, s.data};
    end else if (wb_req.adr == `ECL_OFF_MACLO) begin
      rd_word = s.mac[31:0];
    end else if (wb_req.adr == `ECL_OFF_MACHI) begin
      rd_word = {16'h0, s.mac[47:32]};
    end else if (wb_req.adr == `ECL_OFF_CFG) begin
      rd_word = {s.pme, s.cfg, s.hs, s.fs};
    end else if (wb_req.adr == `ECL_OFF_WAKE) begin
      rd_word = {s.lang, 5'h0, s.wake};
    end else if (wb_req.adr == `ECL_OFF_HWCFG) begin
      rd_word = {29'h0, s.connect, s.rwake, s.emul};
    end else if (wb_req.adr == `ECL_OFF_ATTR) begin
      rd_word = {8'h0, s.doff[s.asel], s.dlen[s.asel], 4'h0, s.asel};
    end else if (wb_req.adr == `ECL_OFF_DRAM) begin
      rd_word = {7'h0, s.daddr, 8'h0, mem_bq};
    end
    wmask = {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}}, {8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};
    wv = (rd_word & ~wmask) | (wb_req.dat & wmask);
    bus_wr = wb_req.cyc & wb_req.stb & wb_req.we & s.ack;
  end

  // Descriptor fetch address: word offset doubled plus the byte index.
  // Offset to address.
  assign desc_a = 9'({s.doff[desc_sel], 1'b0}) + 9'(desc_idx);
  assign tick = (s.div == `ECL_HALF_CYC);
  assign rbyte = {s.sh[6:0], rom_in};

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the serial engine, the loader and the register file.
  always_comb begin
    n = s;
    mem_we = 1'b0;
    mem_a = s.daddr;
    mem_d = 8'h00;
    n.ack = wb_req.cyc & wb_req.stb & ~s.ack;
    n.rdat = rd_word;
    n.dval = desc_rd;
    n.div = (tick || s.st == ECL_IDLE) ? 8'h00 : s.div + 8'h01;
    case (s.st)
      ECL_IDLE: begin
        n.sk = 1'b0;
        n.cs = 1'b0;
        n.busy = 1'b0;
      end
      ECL_HDR: begin
        if (tick && !s.sk) begin
          n.sk = 1'b1;
        end else if (tick) begin
          n.sk = 1'b0;
          if (s.bits != 5'h0) begin
            n.dout = s.sh[19];
            n.sh = {s.sh[18:0], 1'b0};
            n.bits = s.bits - 5'h1;
          end else if (s.cmd == `ECL_CMD_READ || s.load) begin
            n.st = ECL_RD;
            n.bits = 5'd9;
            n.dout = 1'b0;
          end else if (s.cmd == `ECL_CMD_EWEN || s.cmd == `ECL_CMD_EWDS) begin
            n.st = ECL_IDLE;
          end else begin
            n.st = ECL_GAP;
            n.cs = 1'b0;
            n.dout = 1'b0;
          end
        end
      end
      ECL_RD: begin
        if (tick && s.sk) begin
          n.sk = 1'b0;
        end else if (tick) begin
          n.sk = 1'b1;
          n.sh = {s.sh[18:0], rom_in};
          n.bits = s.bits - 5'h1;
          if (s.bits == 5'h1) begin
            n.bits = 5'd8;
            n.bcnt = s.bcnt + 9'h001;
            if (!s.load) begin
              n.data = rbyte;
              n.st = ECL_IDLE;
            end else if (s.bcnt == 9'h000 && rbyte != `ECL_SIGNATURE) begin
              // Signature check. Registers stay untouched on failure.
              n.st = ECL_IDLE;
              n.load = 1'b0;
              n.connect = 1'b1;
            end else begin
              mem_we = 1'b1;
              mem_a = s.bcnt;
              mem_d = rbyte;
              if (s.bcnt >= `ECL_A_MAC0 && s.bcnt < `ECL_A_FSINT) begin
                n.mac[8 * (s.bcnt - `ECL_A_MAC0) +: 8] = rbyte;
              end
              if (s.bcnt == `ECL_A_FSINT) begin
                n.fs = rbyte;
              end
              if (s.bcnt == `ECL_A_HSINT) begin
                n.hs = rbyte;
              end
              if (s.bcnt == `ECL_A_CFG) begin
                n.cfg = rbyte;
              end
              if (s.bcnt == `ECL_A_LANG) begin
                n.lang[7:0] = rbyte;
              end
              if (s.bcnt == `ECL_A_LANG + 9'h001) begin
                n.lang[15:8] = rbyte;
              end
              if (s.bcnt >= `ECL_A_DESC && s.bcnt <= `ECL_A_DESCEND) begin
                if (!s.bcnt[0]) begin
                  n.dlen[4'((s.bcnt - `ECL_A_DESC) >> 1)] = rbyte;
                end else begin
                  n.doff[4'((s.bcnt - `ECL_A_DESC) >> 1)] = rbyte;
                end
              end
              if (s.bcnt == `ECL_A_WAKELO) begin
                n.wake[7:0] = rbyte;
              end
              if (s.bcnt == `ECL_A_WAKEHI) begin
                n.wake[10:8] = rbyte[2:0];
              end
              if (s.bcnt == `ECL_A_PME) begin
                n.pme = rbyte;
              end
              if (s.bcnt == `ECL_A_LAST) begin
                n.st = ECL_IDLE;
                n.load = 1'b0;
                n.loaded = 1'b1;
                n.connect = 1'b1;
              end
            end
          end
          // The last sample keeps the link clock low, so no high phase is ever cut short.
          if (n.st == ECL_IDLE) begin
            n.sk = 1'b0;
          end
        end
      end
      ECL_GAP: begin
        // Chip select drops for one half period so the part starts its write cycle.
        if (tick) begin
          n.cs = 1'b1;
          n.st = ECL_WAIT;
          n.tcnt = 23'h0;
        end
      end
      default: begin
        n.tcnt = s.tcnt + 23'h1;
        // The line still shows the level left from the gap, so trust it after half a period.
        if (rom_in && s.tcnt >= 23'(`ECL_HALF_CYC)) begin
          n.st = ECL_IDLE;
        end else if (s.tcnt == 23'(TMO_CYC - 1)) begin
          n.tmo = 1'b1;
          n.st = ECL_IDLE;
        end
      end
    endcase
    // A reload or soft reset, or a command with busy set, starts the engine.
    if (s.st == ECL_IDLE || !s.busy) begin
      if (bus_wr && wb_req.adr == `ECL_OFF_CMD && !s.busy) begin
        n.cmd = wv[30:28];
        n.addr = wv[8:0];
        if (wv[`ECL_CMD_BUSY]) begin
          n.busy = 1'b1;
          n.tmo = 1'b0;
          n.st = ECL_HDR;
          n.cs = 1'b1;
          n.sh = hdr_word(wv[30:28], wv[8:0], s.data);
          n.bits = (wv[30:28] == `ECL_CMD_WRITE || wv[30:28] == `ECL_CMD_WRAL) ? 5'd20 : 5'd12;
          n.bcnt = wv[8:0];
          if (wv[30:28] == `ECL_CMD_RELOAD) begin
            n.load = 1'b1;
            n.loaded = 1'b0;
            n.sh = hdr_word(`ECL_CMD_READ, 9'h000, 8'h00);
            n.bcnt = 9'h000;
          end
        end
      end else if (soft_reset_request && !s.busy) begin
        n.busy = 1'b1;
        n.load = 1'b1;
        n.loaded = 1'b0;
        n.st = ECL_HDR;
        n.cs = 1'b1;
        n.sh = hdr_word(`ECL_CMD_READ, 9'h000, 8'h00);
        n.bits = 5'd12;
        n.bcnt = 9'h000;
      end
    end
    // Plain register writes; locked while a command runs.
    if (bus_wr && !s.busy) begin
      if (wb_req.adr == `ECL_OFF_DATA) begin
        n.data = wv[7:0];
      end else if (wb_req.adr == `ECL_OFF_MACLO) begin
        n.mac[31:0] = wv;
      end else if (wb_req.adr == `ECL_OFF_MACHI) begin
        n.mac[47:32] = wv[15:0];
      end else if (wb_req.adr == `ECL_OFF_CFG) begin
        {n.pme, n.cfg, n.hs, n.fs} = wv;
      end else if (wb_req.adr == `ECL_OFF_WAKE) begin
        n.lang = wv[31:16];
        n.wake = wv[10:0];
      end else if (wb_req.adr == `ECL_OFF_HWCFG) begin
        n.emul = wv[0];
        n.rwake = wv[1];
      end else if (wb_req.adr == `ECL_OFF_ATTR) begin
        n.asel = wv[3:0];
        if (wv[3:0] < 4'd9) begin
          n.dlen[wv[3:0]] = wv[15:8];
          n.doff[wv[3:0]] = wv[23:16];
          n.attr_wr = 1'b1;
        end
      end else if (wb_req.adr == `ECL_OFF_DRAM) begin
        n.daddr = wv[24:16];
        mem_we = 1'b1;
        mem_a = wv[24:16];
        mem_d = wv[7:0];
        // Remote wake taken only after attributes are set.
        if (s.attr_wr && wv[24:16] == 9'({s.doff[`ECL_HSCFG_IDX], 1'b0}) + 9'(`ECL_CFGATTR_BYTE)) begin
          n.rwake = wv[`ECL_RWAKE_BIT];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; the first load starts straight out of reset.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.st <= ECL_HDR;
      s.load <= 1'b1;
      s.busy <= 1'b1;
      s.cs <= 1'b1;
      s.sh <= {1'b1, 2'b10, 17'h0};
      s.bits <= 5'd12;
      s.mac <= `ECL_RST_MAC;
      s.fs <= `ECL_RST_FS;
      s.hs <= `ECL_RST_HS;
      s.cfg <= `ECL_RST_CFG;
    end else begin
      s <= n;
    end
  end

  // Shared image and descriptor RAM with one write and two registered read ports.
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_a] <= mem_d;
    end
    mem_dq <= mem[desc_a];
    mem_bq <= mem[s.daddr];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs. A zero-length descriptor reads back as zero data.
  assign wb_dat_o = s.rdat;
  assign wb_ack_o = s.ack;
  assign rom_out = '{cs: s.cs, sk: s.sk, di: s.dout};
  assign desc_data = (s.dlen[desc_sel] != 8'h00) ? mem_dq : 8'h00;
  assign desc_valid = s.dval;
  assign usb_connect = s.connect;
  assign cfg_out = '{mac_address: s.mac, fs_interval: s.fs, hs_interval: s.hs,
                     config_flags: s.cfg, pme_flags: s.pme, pin_wake_enables: s.wake,
                     lang_id: s.lang, remote_wake_flag: s.rwake,
                     ram_emulation_enable: s.emul};
endmodule

// >>> rtl/ecl_regs.svh
// Register offsets, field positions, command codes and timing counts of the loader.
`ifndef ECL_REGS_SVH
`define ECL_REGS_SVH
`define ECL_OFF_CMD 8'h00
`define ECL_OFF_DATA 8'h04
`define ECL_OFF_MACLO 8'h08
`define ECL_OFF_MACHI 8'h0C
`define ECL_OFF_CFG 8'h10
`define ECL_OFF_WAKE 8'h14
`define ECL_OFF_HWCFG 8'h18
`define ECL_OFF_ATTR 8'h1C
`define ECL_OFF_DRAM 8'h20
`define ECL_CMD_BUSY 31
`define ECL_CMD_TMO 10
`define ECL_CMD_LOADED 9
`define ECL_CMD_READ 3'h0
`define ECL_CMD_EWDS 3'h1
`define ECL_CMD_EWEN 3'h2
`define ECL_CMD_WRITE 3'h3
`define ECL_CMD_WRAL 3'h4
`define ECL_CMD_ERAL 3'h5
`define ECL_CMD_ERASE 3'h6
`define ECL_CMD_RELOAD 3'h7
`define ECL_SIGNATURE 8'hA5
`define ECL_A_MAC0 9'h001
`define ECL_A_FSINT 9'h007
`define ECL_A_HSINT 9'h008
`define ECL_A_CFG 9'h009
`define ECL_A_LANG 9'h00A
`define ECL_A_DESC 9'h00C
`define ECL_A_DESCEND 9'h01D
`define ECL_A_WAKELO 9'h01E
`define ECL_A_WAKEHI 9'h01F
`define ECL_A_PME 9'h020
`define ECL_A_LAST 9'h1FF
`define ECL_CFGATTR_BYTE 8'h07
`define ECL_HSCFG_IDX 6
`define ECL_RWAKE_BIT 5
`define ECL_RST_FS 8'h01
`define ECL_RST_HS 8'h04
`define ECL_RST_CFG 8'h04
`define ECL_RST_MAC 48'hFFFFFFFFFFFF
`define ECL_HALF_CYC 8'h13
`define ECL_TMO_MS 30
`define ECL_CLK_KHZ 250000
`define ECL_TMO_CYC (`ECL_TMO_MS * `ECL_CLK_KHZ)
`endif

// >>> rtl/ecl_pkg.sv
// Types shared by the configuration loader.
package ecl_pkg;
  typedef enum logic [2:0] {ECL_IDLE, ECL_HDR, ECL_RD, ECL_GAP, ECL_WAIT} ecl_state_e;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } ecl_wb_req_s;
  typedef struct packed {
    logic cs;
    logic sk;
    logic di;
  } ecl_rom_pins_s;
  typedef struct packed {
    logic [47:0] mac_address;
    logic [7:0] fs_interval;
    logic [7:0] hs_interval;
    logic [7:0] config_flags;
    logic [7:0] pme_flags;
    logic [10:0] pin_wake_enables;
    logic [15:0] lang_id;
    logic remote_wake_flag;
    logic ram_emulation_enable;
  } ecl_cfg_s;
  typedef struct packed {
    ecl_state_e st;
    logic load;
    logic busy;
    logic [2:0] cmd;
    logic [8:0] addr;
    logic tmo;
    logic loaded;
    logic [7:0] data;
    logic [47:0] mac;
    logic [7:0] fs;
    logic [7:0] hs;
    logic [7:0] cfg;
    logic [7:0] pme;
    logic [10:0] wake;
    logic [15:0] lang;
    logic emul;
    logic rwake;
    logic attr_wr;
    logic connect;
    logic [3:0] asel;
    logic [8:0] daddr;
    logic [8:0][7:0] dlen;
    logic [8:0][7:0] doff;
    logic [7:0] div;
    logic sk;
    logic cs;
    logic dout;
    logic [19:0] sh;
    logic [4:0] bits;
    logic [8:0] bcnt;
    logic [22:0] tcnt;
    logic ack;
    logic [31:0] rdat;
    logic dval;
  } ecl_st_s;
endpackage

// >>> rtl/ecl_sync.sv
// Three-stage input synchroniser that updates only when the last two stages agree.
`timescale 1ns/1ps
module ecl_sync (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Asynchronous level in, clean level out.
  input wire logic din,
  output logic dout
);
  logic [2:0] st_q;
  logic [2:0] st_d;

  // The first stage feeds only the second; the output moves once stages two and three match.
  always_comb begin
    st_d = {st_q[1:0], din};
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= 3'h0;
      dout <= 1'b0;
    end else begin
      st_q <= st_d;
      dout <= (st_q[1] == st_q[2]) ? st_q[2] : dout;
    end
  end
endmodule

// >>> test/ecl_loader_assertions.sv
// Concurrent checks on the configuration loader's top-level ports.
`timescale 1ns/1ps
module ecl_loader_assertions
  import ecl_pkg::*;
#(
  parameter int TMO_CYC = 200
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Register bus.
  input wire ecl_wb_req_s wb_req,
  input wire logic wb_ack_o,
  // Link and descriptor side.
  input wire ecl_rom_pins_s rom_out,
  input wire logic desc_rd,
  input wire logic desc_valid,
  input wire logic usb_connect
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic sk_prev_q;
  logic [7:0] sk_run_q;
  ////////////////////////////////////////
  // Cycles since the link clock last moved; reset counts as a long idle so the first edge passes.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sk_prev_q <= 1'b0;
      sk_run_q <= 8'hFF;
    end else begin
      sk_prev_q <= rom_out.sk;
      sk_run_q <= (rom_out.sk != sk_prev_q) ? 8'h01 : sk_run_q + {7'h00, sk_run_q != 8'hFF};
    end
  end
  ////////////////////////////////////////
  // A request seen with no answer pending, and the single-cycle answer to it.
  sequence s_req;
    wb_req.cyc && wb_req.stb && !wb_ack_o;
  endsequence
  sequence s_ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_ack_answer: assert property (s_req |=> s_ack_once)
    else $error("bus request not answered by one acknowledge");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_req.cyc && wb_req.stb))
    else $error("acknowledge without a request");
  chk_ack_in_cycle: assert property (wb_ack_o |-> wb_req.cyc && wb_req.stb)
    else $error("acknowledge outside a bus cycle");
  chk_connect_held: assert property (usb_connect |=> usb_connect)
    else $error("port connect dropped");
  chk_connect_late: assert property ($rose(nrst) |-> !usb_connect [*8])
    else $error("port connected before the load");
  chk_desc_answer: assert property (desc_rd |=> desc_valid)
    else $error("descriptor read not answered next cycle");
  chk_desc_cause: assert property (desc_valid |-> $past(desc_rd))
    else $error("descriptor valid without a read");
  chk_sk_half: assert property ((rom_out.sk != sk_prev_q) |-> sk_run_q >= 8'h14)
    else $error("link clock phase shorter than 20 cycles");
  chk_sk_framed: assert property (rom_out.sk |-> rom_out.cs)
    else $error("link clock high outside a frame");
endmodule

bind ecl_loader ecl_loader_assertions #(.TMO_CYC(TMO_CYC)) u_chk (
  .clk(clk), .nrst(nrst), .wb_req(wb_req), .wb_ack_o(wb_ack_o), .rom_out(rom_out),
  .desc_rd(desc_rd), .desc_valid(desc_valid), .usb_connect(usb_connect)
);

// >>> test/ecl_rom_model.sv
// Behavioural serial memory that answers the loader's link frames.
`timescale 1ns/1ps
module ecl_rom_model
  import ecl_pkg::*;
(
  // Link pins from the loader.
  input wire ecl_rom_pins_s pins,
  output logic rom_do,
  // Keeps the data line low, as a memory that never answers.
  input wire logic silent
);
  logic [7:0] mem [512];
  logic [11:0] hdr;
  logic [8:0] hdr_addr;
  int nrise = 0;
  initial rom_do = 1'b1;
  ////////////////////////////////////////
  // Start bit, opcode and address arrive on rising link clocks; idle zeros are skipped.
  always @(posedge pins.sk) begin
    if (pins.cs && (nrise > 0 || pins.di)) begin
      hdr = {hdr[10:0], pins.di};
      nrise++;
      if (nrise == 12) hdr_addr = hdr[8:0];
    end
  end
  ////////////////////////////////////////
  // continuous byte stream
  // silent memory
  // Data moves on falling link clocks, so it is settled well before the loader samples it.
  always @(negedge pins.sk or posedge pins.cs or negedge pins.cs) begin
    if (!pins.cs) begin
      nrise = 0;
      rom_do <= ~rom_do; // No pull on the line, so a released pin shows no stale level.
    end else if (silent) begin
      rom_do <= 1'b0;
    end else if (nrise < 12) begin
      rom_do <= 1'b1;
    end else if (nrise == 12) begin
      rom_do <= 1'b0;
    end else begin
      rom_do <= mem[9'(hdr_addr + (nrise - 13) / 8)][7 - (nrise - 13) % 8];
    end
  end
endmodule

// >>> test/testbench.sv
// Self-checking bench for the configuration loader and its serial memory.
`timescale 1ns/1ps
`include "ecl_regs.svh"
module testbench
  import ecl_pkg::*;
;
  logic clk;
  logic nrst;
  ecl_wb_req_s wb;
  logic [31:0] wb_dat;
  logic wb_ack;
  ecl_rom_pins_s pins;
  logic rom_do;
  logic soft_req;
  logic desc_rd;
  logic [3:0] desc_sel;
  logic [7:0] desc_idx;
  logic [7:0] desc_data;
  logic desc_valid;
  logic usb_connect;
  ecl_cfg_s cfg;
  logic mute;
  logic [31:0] q;
  logic [7:0] im [512];
  int n_mismatch;
  int n_compared;
  ////////////////////////////////////////
  // Design with a short timeout, and the memory on its link.
  ecl_loader #(.TMO_CYC(200)) dut (
    .clk(clk), .nrst(nrst), .wb_req(wb), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack),
    .rom_out(pins), .rom_do(rom_do), .soft_reset_request(soft_req), .desc_rd(desc_rd),
    .desc_sel(desc_sel), .desc_idx(desc_idx), .desc_data(desc_data),
    .desc_valid(desc_valid), .usb_connect(usb_connect), .cfg_out(cfg)
  );
  ecl_rom_model rom (.pins(pins), .rom_do(rom_do), .silent(mute));
  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////
  // Comparison, verdict and bus helpers.
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // One classic cycle; the request stands until ack is sampled, then drops for a cycle.
  task automatic wb_cyc(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb <= {1'b1, 1'b1, we, a, 4'hF, d};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 64);
    q = wb_dat;
    wb <= '0;
    if (wb_ack !== 1'b1) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  // Poll the command register until busy clears; q then holds the final status.
  task automatic wait_idle(input int limit);
    for (int n = 0; n < limit; n++) begin
      wb_cyc(1'b0, `ECL_OFF_CMD, 32'h0);
      if (q[31] === 1'b0) return;
    end
    n_mismatch++;
    tally_and_finish();
  endtask
  // Descriptor byte fetch; the answer comes one cycle after the read strobe.
  task automatic desc(input logic [3:0] s, input logic [7:0] i, input logic [7:0] exp);
    @(posedge clk);
    desc_rd <= 1'b1;
    desc_sel <= s;
    desc_idx <= i;
    @(posedge clk);
    desc_rd <= 1'b0;
    @(posedge clk);
    check("desc_valid", desc_valid, 1'b1); // answer strobe
    check("desc_data", desc_data, exp); // byte address from word offset
  endtask
  ////////////////////////////////////////
  // Scenarios.
  task automatic t_defaults();
    check("mac", cfg.mac_address, 48'hFFFFFFFFFFFF); // default address
    check("intervals", {cfg.hs_interval, cfg.fs_interval}, 16'h0401); // default rates
    check("flags", cfg.config_flags, 8'h04); // default flags
    check("connect", usb_connect, 1'b0); // port held off
    $display("test defaults done");
  endtask
  task automatic t_autoload();
    repeat (1000) @(posedge clk);
    check("connect early", usb_connect, 1'b0); // port held off
    wb_cyc(1'b0, `ECL_OFF_CMD, 32'h0);
    check("busy in load", q[31], 1'b1); // busy while loading
    wait_idle(60000);
    check("loaded", q[9], 1'b1); // success flag
    check("connect", usb_connect, 1'b1); // port released
    check("mac", cfg.mac_address, {im[6], im[5], im[4], im[3], im[2], im[1]}); // address
    check("fs", cfg.fs_interval, im[7]); // full-speed rate
    check("hs", cfg.hs_interval, im[8]); // hi-speed rate
    check("cfg", cfg.config_flags, im[9]); // flags byte
    check("lang", cfg.lang_id, {im[11], im[10]}); // low byte first
    check("wake", cfg.pin_wake_enables, {im[31][2:0], im[30]}); // pin wakes
    check("pme", cfg.pme_flags, im[32]); // event flags
    wb_cyc(1'b0, `ECL_OFF_MACLO, 32'h0);
    check("mac low reg", q, {im[4], im[3], im[2], im[1]}); // register view
    wb_cyc(1'b0, 8'h40, 32'h0);
    check("unmapped", q, 32'h0); // unmapped reads zero
    desc(4'h0, 8'h01, im[9'(im[13] * 2 + 1)]); // first pair
    desc(4'h3, 8'h00, 8'h00); // zero length
    desc(4'h8, 8'h02, im[9'(im[29] * 2 + 2)]); // last pair
    $display("test autoload done");
  endtask
  task automatic t_refetch();
    rom.mem[0] = 8'h00;
    for (int k = 0; k < 2; k++) begin
      wb_cyc(1'b1, `ECL_OFF_CMD, 32'h8000_0055);
      wait_idle(3000);
      wb_cyc(1'b0, `ECL_OFF_DATA, 32'h0);
      check("read data", q[7:0], im[85]); // read command result
      check("read addr", rom.hdr_addr, 9'h055); // read command address
      if (k == 0) begin
        wb_cyc(1'b1, `ECL_OFF_CMD, 32'hF000_0055);
      end else begin
        @(posedge clk);
        soft_req <= 1'b1;
        @(posedge clk);
        soft_req <= 1'b0;
      end
      wait_idle(3000);
      check("refetch start", rom.hdr_addr, 9'h000); // from byte zero
      check("loaded", q[9], 1'b0); // bad signature fails
      check("mac kept", cfg.mac_address, {im[6], im[5], im[4], im[3], im[2], im[1]});
    end
    $display("test refetch done");
  endtask
  task automatic t_timeout();
    @(posedge clk);
    mute <= 1'b1;
    // Erase is a write-type command, so it ends with the ready poll.
    wb_cyc(1'b1, `ECL_OFF_CMD, 32'hE000_0000);
    wait_idle(3000);
    check("timeout", q[10], 1'b1); // silent memory
    mute <= 1'b0;
    wb_cyc(1'b1, `ECL_OFF_CMD, 32'hE000_0000);
    wait_idle(3000);
    check("no timeout", q[10], 1'b0); // answering memory
    $display("test timeout done");
  endtask
  task automatic t_emul();
    // fields, attributes, RAM, then enable
    // A write lands at the acknowledge edge, so each check waits one more edge.
    wb_cyc(1'b1, `ECL_OFF_MACLO, 32'h1122_3344);
    @(posedge clk);
    check("mac low", cfg.mac_address[31:0], 32'h1122_3344); // software fields
    wb_cyc(1'b1, `ECL_OFF_HWCFG, 32'h0);
    @(posedge clk);
    check("rwake off", cfg.remote_wake_flag, 1'b0); // cleared first
    wb_cyc(1'b1, `ECL_OFF_ATTR, 32'h0010_0906);
    wb_cyc(1'b1, `ECL_OFF_DRAM, 32'h0027_0020);
    @(posedge clk);
    check("rwake", cfg.remote_wake_flag, 1'b1); // attribute byte copied
    wb_cyc(1'b1, `ECL_OFF_HWCFG, 32'h3);
    @(posedge clk);
    check("emulation", cfg.ram_emulation_enable, 1'b1); // RAM source
    desc(4'h6, 8'h07, 8'h20); // descriptor from RAM
    $display("test emulation done");
  endtask
  ////////////////////////////////////////
  // Main sequence; the one good load is long because the link clock rate is fixed.
  initial begin
    nrst = 1'b0;
    wb = '0;
    soft_req = 1'b0;
    desc_rd = 1'b0;
    desc_sel = 4'h0;
    desc_idx = 8'h00;
    mute = 1'b0;
    n_mismatch = 0;
    n_compared = 0;
    for (int i = 0; i < 512; i++) im[i] = (i == 0) ? 8'hA5 : (i == 18) ? 8'h00 : 8'(i * 37 + 11);
    rom.mem = im;
    repeat (16) @(posedge clk);
    t_defaults();
    nrst <= 1'b1;
    t_autoload();
    t_refetch();
    t_timeout();
    t_emul();
    tally_and_finish();
  end
endmodule
